/* shared/fpd_pkg.sv */
// Constants and state carrier for the flash erase and deep power-down sequencer.
package fpd_pkg;

  // Opcodes.
  localparam logic [7:0] FPD_OP_BLOCK_ERASE  = 8'hD8;
  localparam logic [7:0] FPD_OP_ARRAY_ERASE  = 8'hC7;
  localparam logic [7:0] FPD_OP_ARRAY_ERASE2 = 8'h60;
  localparam logic [7:0] FPD_OP_DEEP_SLEEP   = 8'hB9;
  localparam logic [7:0] FPD_OP_WAKE_AND_ID  = 8'hAB;
  localparam logic [7:0] FPD_OP_WRITE_ENABLE = 8'h06;

  // Frame lengths in serial clocks and the ceiling of the bit counter.
  localparam logic [5:0] FPD_OPCODE_BITS = 6'h08;
  localparam logic [5:0] FPD_ADDR_FRAME  = 6'h20;
  localparam logic [5:0] FPD_CNT_MAX     = 6'h3F;

  // Block index field of the address and the block count.
  localparam int         FPD_BLK_LSB   = 16;
  localparam int         FPD_BLK_W     = 4;
  localparam logic [7:0] FPD_NUM_BLOCKS = 8'h10;

  // Value that every erased byte reads back as.
  localparam logic [7:0] FPD_ERASED_BYTE = 8'hFF;

  localparam int FPD_CLK_PERIOD_NS = 5;

  typedef enum logic [1:0] {
    FPD_IDLE,
    FPD_ERASE,
    FPD_SLEEP_WAIT,
    FPD_WAKE_WAIT
  } fpd_phase_t;

  typedef struct packed {
    logic [1:0]           csSync;
    logic [1:0]           ckSync;
    logic [1:0]           diSync;
    logic                 csPrev;
    logic                 ckPrev;
    logic [7:0]           shift;
    logic [5:0]           bitCnt;
    logic [7:0]           opcode;
    logic [23:0]          addr;
    fpd_phase_t           phase;
    logic [31:0]          timer;
    logic                 write_enable_latch;
    logic                 sleep;
    logic [7:0]           idReg;
    logic                 serialOut;
    logic                 serialOutEn;
    logic                 eraseStart;
    logic                 eraseAll;
    logic [FPD_BLK_W-1:0] eraseBlock;
    logic                 write_in_progress_flag;
    logic                 standby;
  } fpd_state_t;

  localparam fpd_state_t FPD_ST_RESET = fpd_state_t'(0);

endpackage : fpd_pkg

/* rtl/fpd_ctrl.sv */
// Erase, deep power-down and wake/identifier command sequencer of a serial flash.
`timescale 1ns/1ps

module fpd_ctrl #(
  parameter int             BLOCK_ERASE_NS = 1000000,
  parameter int             ARRAY_ERASE_NS = 4000000,
  parameter int             SLEEP_ENTRY_NS = 3000,
  parameter int             WAKE_NS        = 3000,
  parameter int             WAKE_ID_NS     = 2000,
  parameter logic [7:0]     DEVICE_ID      = 8'h5A  // Arbitrary value.
) (
  // Clock and reset.
  input  wire logic         clock,
  input  wire logic         rst_n,
  // Serial pins.
  input  wire logic         csN,
  input  wire logic         serialClk,
  input  wire logic         serialIn,
  output logic              serialOut,
  output logic              serialOutEn,
  // Protection and shared busy.
  input  wire logic [2:0]   blockProtect,
  input  wire logic         otherBusy,
  // Array erase requests.
  output logic              eraseStart,
  output logic              eraseAll,
  output logic [3:0]        eraseBlock,
  // Status.
  output logic              writeInProgressFlag,
  output logic              writeEnableLatch,
  output logic              deepSleep,
  output logic              standby
);

  // Erase times round up; worst-case delays round down, at least one cycle.
  localparam logic [31:0] BLOCK_CYC = 32'((BLOCK_ERASE_NS + fpd_pkg::FPD_CLK_PERIOD_NS - 1)
                                         / fpd_pkg::FPD_CLK_PERIOD_NS);
  localparam logic [31:0] ARRAY_CYC = 32'((ARRAY_ERASE_NS + fpd_pkg::FPD_CLK_PERIOD_NS - 1)
                                         / fpd_pkg::FPD_CLK_PERIOD_NS);
  localparam int          SLEEP_RAW = SLEEP_ENTRY_NS / fpd_pkg::FPD_CLK_PERIOD_NS;
  localparam int          WAKE_RAW  = WAKE_NS / fpd_pkg::FPD_CLK_PERIOD_NS;
  localparam int          WID_RAW   = WAKE_ID_NS / fpd_pkg::FPD_CLK_PERIOD_NS;
  localparam logic [31:0] SLEEP_CYC = 32'((SLEEP_RAW < 1) ? 1 : SLEEP_RAW);
  localparam logic [31:0] WAKE_CYC  = 32'((WAKE_RAW < 1) ? 1 : WAKE_RAW);
  localparam logic [31:0] WID_CYC   = 32'((WID_RAW < 1) ? 1 : WID_RAW);

  fpd_pkg::fpd_state_t st_r;
  fpd_pkg::fpd_state_t st_nxt;

  logic                          cs;
  logic                          ck;
  logic                          di;
  logic                          ckRise;
  logic                          ckFall;
  logic                          csFall;
  logic                          csRise;
  logic                          idPhase;
  logic                          blkProt;
  logic [fpd_pkg::FPD_BLK_W-1:0] blk;

  // Only the second stage of each synchroniser is read.
  assign cs     = st_r.csSync[1];
  assign ck     = st_r.ckSync[1];
  assign di     = st_r.diSync[1];
  assign ckRise = ck & ~st_r.ckPrev;
  assign ckFall = ~ck & st_r.ckPrev;
  assign csFall = ~cs & st_r.csPrev;
  assign csRise = cs & ~st_r.csPrev;
  assign blk    = st_r.addr[fpd_pkg::FPD_BLK_LSB +: fpd_pkg::FPD_BLK_W];

  // Protection grows from the top block downward: a field of n guards 2**(n-1) blocks, all 16 once n is 5 or more.
  always_comb begin
    logic [7:0] span;
    span = 8'h00;
    if (blockProtect != 3'h0) begin
      span = 8'h01 << (blockProtect - 3'h1);
    end
    blkProt = (blockProtect != 3'h0) &&
              ((8'(blk) + span) >= fpd_pkg::FPD_NUM_BLOCKS);
  end

  // Readout is only offered when no cycle of any kind is running.
  assign idPhase = (st_r.bitCnt >= fpd_pkg::FPD_ADDR_FRAME) &&
                   (st_r.opcode == fpd_pkg::FPD_OP_WAKE_AND_ID) &&
                   (st_r.phase == fpd_pkg::FPD_IDLE) && !otherBusy;

  always_comb begin
    st_nxt            = st_r;
    st_nxt.csSync     = {st_r.csSync[0], csN};
    st_nxt.ckSync     = {st_r.ckSync[0], serialClk};
    st_nxt.diSync     = {st_r.diSync[0], serialIn};
    st_nxt.csPrev     = cs;
    st_nxt.ckPrev     = ck;
    st_nxt.eraseStart = 1'b0;

    if (st_r.phase != fpd_pkg::FPD_IDLE) begin
      if (st_r.timer <= 32'h1) begin
        case (st_r.phase)
          fpd_pkg::FPD_SLEEP_WAIT: st_nxt.sleep = 1'b1;
          fpd_pkg::FPD_WAKE_WAIT:  st_nxt.sleep = 1'b0;
          default: ;
        endcase
        st_nxt.phase = fpd_pkg::FPD_IDLE;
        st_nxt.timer = 32'h0;
      end else begin
        st_nxt.timer = st_r.timer - 32'h1;
      end
    end

    if (csFall) begin
      st_nxt.bitCnt      = 6'h00;
      st_nxt.serialOutEn = 1'b0;
    end else if (!cs) begin
      if (ckRise) begin
        st_nxt.shift = {st_r.shift[6:0], di};
        if (st_r.bitCnt != fpd_pkg::FPD_CNT_MAX) begin
          st_nxt.bitCnt = st_r.bitCnt + 6'h01;
        end
        if (st_r.bitCnt == fpd_pkg::FPD_OPCODE_BITS - 6'h01) begin
          st_nxt.opcode = {st_r.shift[6:0], di};
        end else if (st_r.bitCnt < fpd_pkg::FPD_ADDR_FRAME) begin
          st_nxt.addr = {st_r.addr[22:0], di};
        end
        if (st_r.bitCnt == fpd_pkg::FPD_ADDR_FRAME - 6'h01) begin
          st_nxt.idReg = DEVICE_ID;
        end
      end
      if (ckFall && idPhase) begin
        st_nxt.serialOut   = st_r.idReg[7];
        st_nxt.serialOutEn = 1'b1;
        st_nxt.idReg       = {st_r.idReg[6:0], st_r.idReg[7]};
      end
    end else if (csRise) begin
      st_nxt.serialOutEn = 1'b0;
      // Frames arriving while any timed cycle runs are dropped whole.
      if (st_r.phase == fpd_pkg::FPD_IDLE && !otherBusy) begin
        if (st_r.sleep) begin
          if (st_r.opcode == fpd_pkg::FPD_OP_WAKE_AND_ID &&
              st_r.bitCnt >= fpd_pkg::FPD_OPCODE_BITS) begin
            st_nxt.phase = fpd_pkg::FPD_WAKE_WAIT;
            st_nxt.timer = (st_r.bitCnt == fpd_pkg::FPD_OPCODE_BITS) ? WAKE_CYC : WID_CYC;
          end
        end else begin
          case (st_r.opcode)
            fpd_pkg::FPD_OP_WRITE_ENABLE: begin
              if (st_r.bitCnt == fpd_pkg::FPD_OPCODE_BITS) begin
                st_nxt.write_enable_latch = 1'b1;
              end
            end
            fpd_pkg::FPD_OP_BLOCK_ERASE: begin
              if (st_r.bitCnt == fpd_pkg::FPD_ADDR_FRAME && st_r.write_enable_latch && !blkProt) begin
                st_nxt.phase      = fpd_pkg::FPD_ERASE;
                st_nxt.timer      = BLOCK_CYC;
                st_nxt.write_enable_latch        = 1'b0;
                st_nxt.eraseStart = 1'b1;
                st_nxt.eraseAll   = 1'b0;
                st_nxt.eraseBlock = blk;
              end
            end
            fpd_pkg::FPD_OP_ARRAY_ERASE,
            fpd_pkg::FPD_OP_ARRAY_ERASE2: begin
              if (st_r.bitCnt == fpd_pkg::FPD_OPCODE_BITS && st_r.write_enable_latch &&
                  blockProtect == 3'h0) begin
                st_nxt.phase      = fpd_pkg::FPD_ERASE;
                st_nxt.timer      = ARRAY_CYC;
                st_nxt.write_enable_latch        = 1'b0;
                st_nxt.eraseStart = 1'b1;
                st_nxt.eraseAll   = 1'b1;
              end
            end
            fpd_pkg::FPD_OP_DEEP_SLEEP: begin
              if (st_r.bitCnt == fpd_pkg::FPD_OPCODE_BITS) begin
                st_nxt.phase = fpd_pkg::FPD_SLEEP_WAIT;
                st_nxt.timer = SLEEP_CYC;
              end
            end
            default: ;
          endcase
        end
      end
    end

    st_nxt.write_in_progress_flag     = (st_nxt.phase == fpd_pkg::FPD_ERASE) || otherBusy;
    // A cycle run from elsewhere keeps the device out of standby as well.
    st_nxt.standby = cs && (st_nxt.phase == fpd_pkg::FPD_IDLE) && !st_nxt.sleep && !otherBusy;
  end

  // Sleep is never remembered across reset, which stands in for power-up.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_r <= fpd_pkg::FPD_ST_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign serialOut           = st_r.serialOut;
  assign serialOutEn         = st_r.serialOutEn;
  assign eraseStart          = st_r.eraseStart;
  assign eraseAll            = st_r.eraseAll;
  assign eraseBlock          = st_r.eraseBlock;
  assign writeInProgressFlag = st_r.write_in_progress_flag;
  assign writeEnableLatch    = st_r.write_enable_latch;
  assign deepSleep           = st_r.sleep;
  assign standby             = st_r.standby;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  AST_ERASE_NEEDS_WEL: assert property (
    $rose(eraseStart) |-> $past(writeEnableLatch) && !writeEnableLatch)
    else $error("Erase started without the write-enable latch.");

  AST_BLOCK_FRAME_LEN: assert property (
    eraseStart && !eraseAll |-> $past(st_r.bitCnt) == fpd_pkg::FPD_ADDR_FRAME &&
                                $past(st_r.opcode) == fpd_pkg::FPD_OP_BLOCK_ERASE)
    else $error("Block erase started from a wrong frame.");

  AST_WIP_DURING_ERASE: assert property (
    eraseStart |-> writeInProgressFlag ##1 writeInProgressFlag)
    else $error("Progress flag not raised by an erase.");

  AST_WIP_ENDS: assert property (
    st_r.phase == fpd_pkg::FPD_ERASE && st_r.timer == 32'h1 && !otherBusy |=> !writeInProgressFlag)
    else $error("Progress flag did not fall at erase end.");

  AST_PROTECTED_BLOCK: assert property (
    eraseStart && !eraseAll |-> !$past(blkProt))
    else $error("Protected block erased.");

  AST_ARRAY_PROTECT: assert property (
    eraseStart && eraseAll |-> $past(blockProtect) == 3'h0)
    else $error("Array erase with protection set.");

  AST_SLEEP_NO_ERASE: assert property (
    deepSleep |-> !eraseStart)
    else $error("Erase started while in deep sleep.");

  AST_STANDBY_NOT_SLEEP: assert property (
    standby |-> !deepSleep && !writeInProgressFlag)
    else $error("Standby shown together with sleep or a cycle.");

  AST_SLEEP_NOT_WHEN_BUSY: assert property (
    $rose(st_r.phase == fpd_pkg::FPD_SLEEP_WAIT) |-> !$past(writeInProgressFlag))
    else $error("Deep sleep accepted during a cycle.");

  AST_ID_ONLY_AFTER_FRAME: assert property (
    $rose(serialOutEn) |-> st_r.opcode == fpd_pkg::FPD_OP_WAKE_AND_ID &&
                           st_r.bitCnt >= fpd_pkg::FPD_ADDR_FRAME)
    else $error("Identifier driven outside its frame.");

  AST_ID_CLEARED_ON_DESELECT: assert property (
    csRise |=> !serialOutEn)
    else $error("Identifier output still enabled after deselect.");

  AST_ID_MSB_FIRST: assert property (
    ckFall && !cs && !csFall && idPhase |=> serialOut == $past(st_r.idReg[7]))
    else $error("Identifier bit out of order.");

  AST_SLEEP_AFTER_DELAY: assert property (
    st_r.phase == fpd_pkg::FPD_SLEEP_WAIT && st_r.timer <= 32'h1 |=> deepSleep)
    else $error("Deep sleep not entered at the end of its delay.");

  AST_SLEEP_ONLY_BY_OPCODE: assert property (
    $rose(deepSleep) |-> $past(st_r.phase) == fpd_pkg::FPD_SLEEP_WAIT)
    else $error("Deep sleep entered without its delay.");

  AST_WAKE_ONLY_FROM_SLEEP: assert property (
    $rose(st_r.phase == fpd_pkg::FPD_WAKE_WAIT) |-> $past(deepSleep) &&
                                                   $past(st_r.opcode) == fpd_pkg::FPD_OP_WAKE_AND_ID)
    else $error("Wake sequence started outside deep sleep.");

  AST_WAKE_LEAVES_SLEEP: assert property (
    st_r.phase == fpd_pkg::FPD_WAKE_WAIT && st_r.timer <= 32'h1 |=> !deepSleep)
    else $error("Deep sleep not left at the end of the wake delay.");

  AST_STANDBY_NEEDS_DESELECT: assert property (
    standby |-> $past(cs))
    else $error("Standby shown while selected.");

  AST_ERASE_BLOCK_INDEX: assert property (
    eraseStart && !eraseAll |-> eraseBlock == $past(blk))
    else $error("Erase aimed at a block other than the addressed one.");

endmodule : fpd_ctrl

/* tb/fpd_host_model.sv */
// Host controller model that frames instructions on the serial pins of the sequencer.
`timescale 1ns/1ps
module fpd_host_model (
  // Clock.
  input  wire logic clock,
  // Serial pins.
  output logic      csN,
  output logic      serialClk,
  output logic      serialIn,
  input  wire logic serialOut,
  input  wire logic serialOutEn
);
  logic enSeen;

  initial begin
    csN       = 1'b1;
    serialClk = 1'b0;
    serialIn  = 1'b0;
    enSeen    = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : hold

  // Every pin level stands five clocks, since the device only sees edges through its synchronisers.
  task automatic frame(input logic [7:0] op, input logic [23:0] addr, input int nAddr, input int nRd,
                       output logic [15:0] rd);
    logic [31:0] bits;
    bits   = {op, addr};
    rd     = '0;
    enSeen = 1'b0;
    hold(1);
    csN = 1'b0;
    for (int i = 0; i < 8 + nAddr; i++) begin
      serialIn = bits[31 - i];
      hold(5);
      serialClk = 1'b1;
      hold(5);
      serialClk = 1'b0;
    end
    for (int i = 0; i < nRd; i++) begin
      hold(5);
      rd     = {rd[14:0], serialOut};
      enSeen = enSeen | (serialOutEn === 1'b1);
      serialClk = 1'b1;
      hold(5);
      serialClk = 1'b0;
    end
    hold(5);
    csN = 1'b1;
    // The data line is left toggled so that a stale level is never mistaken for a bit.
    serialIn = ~serialIn;
    hold(5);
  endtask : frame
endmodule : fpd_host_model

/* tb/tb_top.sv */
// Self-checking testbench of the erase and deep power-down sequencer.
`timescale 1ns/1ps
module tb_top;
  localparam logic [7:0] ID_VAL = 8'h5A; // Arbitrary identifier value.
  logic        clock;
  logic        rst_n;
  logic        otherBusy;
  logic        csN;
  logic        serialClk;
  logic        serialIn;
  logic        serialOut;
  logic        serialOutEn;
  logic [2:0]  blockProtect;
  logic        eraseStart;
  logic        eraseAll;
  logic [3:0]  eraseBlock;
  logic        write_in_progress_flag;
  logic        write_enable_latch;
  logic        deepSleep;
  logic        standby;
  logic [15:0] rd;
  logic        lastAll;
  logic [3:0]  lastBlk;
  int          bad_count = 0;
  int          comparisons = 0;
  int          starts = 0;

  initial clock = 1'b0;
  always #2.5 clock = ~clock;

  // The wake delay after a readout is longer than the plain wake delay so the two paths can be told apart.
  fpd_ctrl #(.BLOCK_ERASE_NS(500), .ARRAY_ERASE_NS(500), .SLEEP_ENTRY_NS(50), .WAKE_NS(50),
             .WAKE_ID_NS(100), .DEVICE_ID(ID_VAL)) DUT (
    .clock               (clock),
    .rst_n               (rst_n),
    .csN                 (csN),
    .serialClk           (serialClk),
    .serialIn            (serialIn),
    .serialOut           (serialOut),
    .serialOutEn         (serialOutEn),
    .blockProtect        (blockProtect),
    .otherBusy           (otherBusy),
    .eraseStart          (eraseStart),
    .eraseAll            (eraseAll),
    .eraseBlock          (eraseBlock),
    .writeInProgressFlag (write_in_progress_flag),
    .writeEnableLatch    (write_enable_latch),
    .deepSleep           (deepSleep),
    .standby             (standby)
  );

  fpd_host_model HOST (
    .clock       (clock),
    .csN         (csN),
    .serialClk   (serialClk),
    .serialIn    (serialIn),
    .serialOut   (serialOut),
    .serialOutEn (serialOutEn)
  );

  always @(posedge clock) if (eraseStart === 1'b1) begin
    starts++;
    lastAll = eraseAll;
    lastBlk = eraseBlock;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results

  task automatic wait_idle();
    int n;
    n = 0;
    while (write_in_progress_flag !== 1'b0 && n < 400) begin
      HOST.hold(1);
      n++;
    end
    check(16'(write_in_progress_flag), 16'h0000);
  endtask : wait_idle

  task automatic erase(input logic [7:0] op, input int nAddr, input logic [2:0] bp);
    blockProtect = bp;
    HOST.frame(8'h06, 24'h000000, 0, 0, rd);
    HOST.frame(op, 24'h05ABCD, nAddr, 0, rd);
  endtask : erase

  task automatic t_block();
    int s0;
    s0 = starts;
    HOST.frame(fpd_pkg::FPD_OP_BLOCK_ERASE, 24'h05ABCD, 24, 0, rd);
    HOST.hold(10);
    check(16'(starts - s0), 16'h0000);
    erase(fpd_pkg::FPD_OP_BLOCK_ERASE, 24, 3'h0);
    check(16'(write_in_progress_flag), 16'h0001);
    check(16'(write_enable_latch), 16'h0000);
    check(16'(standby), 16'h0000);
    check(16'(starts - s0), 16'h0001);
    check({lastAll, 11'h000, lastBlk}, 16'h0005);
    wait_idle();
    HOST.hold(5);
    check(16'(standby), 16'h0001);
  endtask : t_block

  task automatic t_refuse();
    int s0;
    s0 = starts;
    erase(fpd_pkg::FPD_OP_BLOCK_ERASE, 23, 3'h0);
    HOST.hold(10);
    check(16'(starts - s0), 16'h0000);
    erase(fpd_pkg::FPD_OP_BLOCK_ERASE, 24, 3'h7);
    HOST.hold(10);
    check(16'(starts - s0), 16'h0000);
    erase(fpd_pkg::FPD_OP_ARRAY_ERASE, 0, 3'h1);
    HOST.hold(10);
    check(16'(starts - s0), 16'h0000);
  endtask : t_refuse

  task automatic t_array();
    int s0;
    for (int k = 0; k < 2; k++) begin
      s0 = starts;
      erase(k ? fpd_pkg::FPD_OP_ARRAY_ERASE2 : fpd_pkg::FPD_OP_ARRAY_ERASE, 0, 3'h0);
      check(16'(starts - s0), 16'h0001);
      check(16'(lastAll), 16'h0001);
      wait_idle();
    end
  endtask : t_array

  task automatic t_sleep();
    int s0;
    HOST.frame(fpd_pkg::FPD_OP_DEEP_SLEEP, 24'h000000, 0, 0, rd);
    check(16'(deepSleep), 16'h0000);
    HOST.hold(30);
    check({deepSleep, standby}, 16'h0002);
    s0 = starts;
    erase(fpd_pkg::FPD_OP_ARRAY_ERASE, 0, 3'h0);
    HOST.hold(10);
    check(16'(starts - s0), 16'h0000);
    check({write_enable_latch, deepSleep}, 16'h0001);
    HOST.frame(fpd_pkg::FPD_OP_WAKE_AND_ID, 24'h000000, 0, 0, rd);
    HOST.hold(30);
    check({deepSleep, standby}, 16'h0001);
    HOST.frame(fpd_pkg::FPD_OP_DEEP_SLEEP, 24'h000000, 0, 0, rd);
    HOST.hold(30);
    HOST.frame(fpd_pkg::FPD_OP_WAKE_AND_ID, 24'h000000, 24, 8, rd);
    check(rd, {8'h00, ID_VAL});
    HOST.hold(10);
    check({deepSleep, standby}, 16'h0002);
    HOST.hold(20);
    check({deepSleep, standby}, 16'h0001);
    HOST.frame(fpd_pkg::FPD_OP_DEEP_SLEEP, 24'h000000, 0, 0, rd);
    HOST.hold(30);
    check(16'(deepSleep), 16'h0001);
    rst_n = 1'b0;
    HOST.hold(3);
    rst_n = 1'b1;
    HOST.hold(10);
    check(16'(deepSleep), 16'h0000);
  endtask : t_sleep

  task automatic t_id();
    HOST.frame(fpd_pkg::FPD_OP_WAKE_AND_ID, 24'h000000, 24, 16, rd);
    check(rd, {ID_VAL, ID_VAL});
    check({HOST.enSeen, serialOutEn}, 16'h0002);
  endtask : t_id

  task automatic t_busy();
    otherBusy = 1'b1;
    HOST.frame(fpd_pkg::FPD_OP_DEEP_SLEEP, 24'h000000, 0, 0, rd);
    HOST.hold(30);
    check({write_in_progress_flag, deepSleep}, 16'h0002);
    HOST.frame(fpd_pkg::FPD_OP_WAKE_AND_ID, 24'h000000, 24, 8, rd);
    check(16'(HOST.enSeen), 16'h0000);
    otherBusy = 1'b0;
    HOST.hold(5);
  endtask : t_busy

  initial begin
    rst_n        = 1'b0;
    otherBusy    = 1'b0;
    blockProtect = 3'h0;
    repeat (10) @(posedge clock);
    #1 rst_n = 1'b1;
    HOST.hold(5);
    check({write_in_progress_flag, deepSleep}, 16'h0000);
    t_block();
    t_refuse();
    t_array();
    t_sleep();
    t_id();
    t_busy();
    results();
  end

  // The planned sequence needs well under a third of this span.
  initial begin
    #300000;
    bad_count++;
    results();
  end
endmodule : tb_top
